// ### bench/aomst_host.sv
// apb master model standing in for the host processor.
// assumes the bench calls xfer from procedural code, one call at a time.
`default_nettype none

module aomst_host (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  output logic      [11:0] o_paddr,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic      [31:0] o_pwdata,
  output logic      [3:0]  o_pstrb
);
  timeunit 1ns;
  timeprecision 1ns;

  // bus idle from time zero
  initial begin
    o_paddr   = 12'h000;
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_pwdata  = 32'h00000000;
    o_pstrb   = 4'h0;
  end

  // one transfer: setup, then access held until ready is seen
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge i_clk);
    o_psel    <= 1'b1;
    o_penable <= 1'b0;
    o_paddr   <= {2'b00, idx, 2'b00};
    o_pwrite  <= wr;
    o_pwdata  <= {24'h000000, wd};
    o_pstrb   <= 4'hF;
    @(posedge i_clk);
    o_penable <= 1'b1;
    do @(posedge i_clk); while (i_pready !== 1'b1);
    rd = i_prdata;
    err = i_pslverr;
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    o_pwdata  <= ~o_pwdata;  // released data shows no stale value
  endtask
endmodule // aomst_host

`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the offset and magnetic status block.
// assumes the host model drives apb; samples are driven here.
`default_nettype none

module tb;
  import aomst_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk;
  logic        nrst;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  aomst_acc_s  acc_in;
  aomst_mag_s  mag_in;
  int          err_total;
  int          cmp_count;
  int          cyc = 0;

  aomst_host host (.i_clk(clk), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr),
    .o_paddr(paddr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_pwdata(pwdata), .o_pstrb(pstrb));

  aomst_top uut (.i_clk(clk), .i_nrst(nrst), .i_paddr(paddr), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_acc(acc_in),
    .i_mag(mag_in), .o_irq(irq));

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b1, idx, d, q, e);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b0, idx, 8'h00, q, e);
    chk(q, {24'h000000, exp});
  endtask

  // irq level checked one edge after the write landed
  task automatic irq_is(input logic exp);
    @(posedge clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic acc(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    @(posedge clk);
    acc_in <= {1'b1, z, y, x};
    @(posedge clk);
    acc_in.valid <= 1'b0;
  endtask

  task automatic mag(input logic [2:0] d, input logic [15:0] x, input logic [15:0] y,
                     input logic [15:0] z);
    @(posedge clk);
    mag_in <= {d, z, y, x};
    @(posedge clk);
    mag_in.done <= 3'b000;
  endtask

  // reset values of the map
  task automatic t_reset();
    for (int i = 0; i < 3; i++) rd(IDX_OFF[i], 8'h00);
    rd(IDX_MAG_STS, 8'h00);
    rd(IDX_IRQ_MSK, 8'h00);
  endtask

  // offsets: standby-only writes, signed 2 mg counts, saturation
  task automatic t_offset();
    logic [15:0] ex [3];
    logic [31:0] q;
    logic        e;
    ex = '{16'h0028, 16'h00FE, 16'h8000};
    wr(IDX_CTRL, 8'h00);
    wr(IDX_OFF[0], 8'hE2);
    wr(IDX_OFF[1], 8'h7F);
    wr(IDX_OFF[2], 8'h80);
    rd(IDX_OFF[0], 8'hE2);
    rd(IDX_OFF[1], 8'h7F);
    rd(IDX_OFF[2], 8'h80);
    wr(IDX_CTRL, 8'h01);
    rd(IDX_CTRL, 8'h01);
    wr(IDX_OFF[0], 8'h11);
    rd(IDX_OFF[0], 8'hE2);
    acc(16'h0064, 16'h0000, 16'h8010);
    for (int i = 0; i < 3; i++) begin
      rd(IDX_ACC_HI[i], ex[i][15:8]);
      rd(IDX_ACC_LO[i], ex[i][7:0]);
    end
    // sample stored and refused write both latched, mask still closed
    rd(IDX_IRQ_STS, 8'h09);
    irq_is(1'b0);
    wr(IDX_IRQ_MSK, 8'h08);
    irq_is(1'b1);
    wr(IDX_IRQ_STS, 8'h08);
    irq_is(1'b0);
    rd(IDX_IRQ_STS, 8'h01);
    host.xfer(1'b0, 8'h7F, 8'h00, q, e);
    chk({31'h0, e}, 32'h00000001);
  endtask

  // magnetic ready, overwrite and set flags
  task automatic t_mag();
    logic [15:0] v [3];
    v = '{16'h1234, 16'hFEDC, 16'h8001};
    mag(3'b111, v[0], v[1], v[2]);
    rd(IDX_MAG_STS, 8'h0F);
    for (int i = 0; i < 3; i++) begin
      rd(IDX_MAG_HI[i], v[i][15:8]);
      rd(IDX_MAG_LO[i], v[i][7:0]);
    end
    rd(IDX_MAG_STS, 8'h00);
    mag(3'b001, 16'h0102, 16'h0000, 16'h0000);
    rd(IDX_MAG_STS, 8'h01);
    mag(3'b001, 16'h0304, 16'h0000, 16'h0000);
    rd(IDX_MAG_STS, 8'h91);
    rd(IDX_MAG_HI[0], 8'h03);
    rd(IDX_MAG_STS, 8'h80);
    rd(IDX_MAG_HI[1], 8'hFE);
    rd(IDX_MAG_HI[2], 8'h80);
    rd(IDX_MAG_STS, 8'h00);
    // set-ready and overwrite events latched in the interrupt status
    rd(IDX_IRQ_STS, 8'h07);
    wr(IDX_IRQ_MSK, 8'h06);
    irq_is(1'b1);
  endtask

  // main sequence
  initial begin
    err_total = 0;
    cmp_count = 0;
    nrst = 1'b0;
    acc_in = '0;
    mag_in = '0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_offset();
    t_mag();
    results();
  end
endmodule // tb

`default_nettype wire

// ### src/aomst_pkg.sv
// package for the accelerometer offset and magnetometer status block:
// register indices, field positions, reset values and sample carriers.
// assumes APB byte address = 4 * register index, data in the low byte.
`default_nettype none

package aomst_pkg;

  localparam int AXES = 3;

  // raw samples arrive from the acquisition logic on the same clock
  typedef struct packed {
    logic             valid;    // one-cycle strobe, all three axes
    logic [2:0][15:0] axis;     // signed, 1 mg per count, [0] = x
  } aomst_acc_s;

  typedef struct packed {
    logic [2:0]       done;     // one-cycle per-axis completion strobes
    logic [2:0][15:0] axis;     // signed, 0.1 uT per count, [0] = x
  } aomst_mag_s;

  typedef logic [7:0] aomst_idx_t;

  // register indices (byte address = index * 4)
  localparam aomst_idx_t IDX_CTRL     = 8'h2A;
  localparam aomst_idx_t IDX_MAG_STS  = 8'h32;
  localparam aomst_idx_t IDX_IRQ_STS  = 8'h60;
  localparam aomst_idx_t IDX_IRQ_MSK  = 8'h61;
  localparam aomst_idx_t [2:0] IDX_ACC_HI = {8'h05, 8'h03, 8'h01};
  localparam aomst_idx_t [2:0] IDX_ACC_LO = {8'h06, 8'h04, 8'h02};
  localparam aomst_idx_t [2:0] IDX_OFF    = {8'h31, 8'h30, 8'h2F};
  localparam aomst_idx_t [2:0] IDX_MAG_HI = {8'h37, 8'h35, 8'h33};
  localparam aomst_idx_t [2:0] IDX_MAG_LO = {8'h38, 8'h36, 8'h34};

  // field positions
  localparam int CTRL_ACTIVE_BIT = 0;
  localparam int IRQ_ACC_DONE    = 0;
  localparam int IRQ_MAG_SET     = 1;
  localparam int IRQ_MAG_OW      = 2;
  localparam int IRQ_OFF_REFUSED = 3;
  localparam int IRQ_W           = 4;

  // reset values
  localparam logic [7:0]       RST_OFF  = 8'h00;
  localparam logic             RST_CTRL = 1'b0;
  localparam logic [IRQ_W-1:0] RST_MSK  = 4'h0;

  // one offset count is 2 mg, i.e. two sample counts
  localparam int          OFF_SHIFT = 1;
  localparam logic [15:0] SAT_POS   = 16'h7FFF;
  localparam logic [15:0] SAT_NEG   = 16'h8000;

endpackage : aomst_pkg

`default_nettype wire

// ### src/aomst_top.sv
// accelerometer offset correction and magnetometer sample status, APB slave.
// assumes samples and strobes come from logic on i_clk; zero-wait APB.
`default_nettype none

module aomst_top (
  input  wire logic                 i_clk,
  input  wire logic                 i_nrst,
  input  wire logic [11:0]          i_paddr,
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [31:0]          i_pwdata,
  input  wire logic [3:0]           i_pstrb,
  output logic      [31:0]          o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  input  wire aomst_pkg::aomst_acc_s i_acc,
  input  wire aomst_pkg::aomst_mag_s i_mag,
  output logic                      o_irq
);
  import aomst_pkg::*;

  logic [7:0]             idx;
  logic                   addr_ok;
  logic                   setup;
  logic                   access;
  logic                   wr_ok;
  logic                   rd_ok;
  logic [31:0]            rd_word;
  logic                   rd_hit;
  logic                   active_ff;
  logic [2:0][7:0]        acc_off_ff;
  logic [2:0][15:0]       acc_out_ff;
  logic [2:0][15:0]       mag_out_ff;
  logic [2:0]             mag_dr_ff;
  logic [2:0]             mag_ow_ff;
  logic                   set_dr_ff;
  logic                   set_ow_ff;
  logic [2:0]             seen_ff;
  logic [IRQ_W-1:0]       irq_sts_ff;
  logic [IRQ_W-1:0]       irq_msk_ff;
  logic [31:0]            prdata_ff;
  logic                   slverr_ff;
  logic [2:0]             mag_new;
  logic [2:0]             hi_read;
  logic [2:0]             ow_evt;
  logic [2:0]             nxt_dr;
  logic                   set_new;
  logic                   all_read;
  logic                   off_refused;
  logic [IRQ_W-1:0]       irq_evt;
  logic [7:0]             mag_sts;

  // saturating add of a scaled signed offset to a signed sample
  function automatic logic [15:0] sat_add(input logic [15:0] raw, input logic [7:0] off);
    logic [16:0] sum;
    sum = {raw[15], raw} + ({{9{off[7]}}, off} << OFF_SHIFT); // 2 mg per offset count
    if (sum[16] != sum[15]) begin
      return sum[16] ? SAT_NEG : SAT_POS;
    end
    return sum[15:0];
  endfunction

  // apb phase and address decode
  assign idx     = i_paddr[9:2];
  assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr[11:10] == 2'h0);
  assign setup   = i_psel & ~i_penable;
  assign access  = i_psel & i_penable;
  assign wr_ok   = access & i_pwrite & ~slverr_ff;
  assign rd_ok   = access & ~i_pwrite & ~slverr_ff;

  // zero-wait slave; data and error prepared in the setup cycle
  assign o_pready  = 1'b1;
  assign o_prdata  = prdata_ff;
  assign o_pslverr = slverr_ff & access;

  assign mag_sts = {set_ow_ff, mag_ow_ff, set_dr_ff, mag_dr_ff};

  // read multiplexer
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b0;
    if (!addr_ok) begin
      rd_hit = 1'b0;
    end else if (idx == IDX_CTRL) begin
      rd_hit  = 1'b1;
      rd_word = {31'h0000_0000, active_ff};
    end else if (idx == IDX_MAG_STS) begin
      rd_hit  = 1'b1;
      rd_word = {24'h00_0000, mag_sts};
    end else if (idx == IDX_IRQ_STS) begin
      rd_hit  = 1'b1;
      rd_word = {28'h000_0000, irq_sts_ff};
    end else if (idx == IDX_IRQ_MSK) begin
      rd_hit  = 1'b1;
      rd_word = {28'h000_0000, irq_msk_ff};
    end
    for (int i = 0; i < AXES; i++) begin
      if (addr_ok && idx == IDX_OFF[i]) begin
        rd_hit  = 1'b1;
        rd_word = {24'h00_0000, acc_off_ff[i]};
      end
      if (addr_ok && idx == IDX_ACC_HI[i]) begin
        rd_hit  = 1'b1;
        rd_word = {24'h00_0000, acc_out_ff[i][15:8]};
      end
      if (addr_ok && idx == IDX_ACC_LO[i]) begin
        rd_hit  = 1'b1;
        rd_word = {24'h00_0000, acc_out_ff[i][7:0]};
      end
      if (addr_ok && idx == IDX_MAG_HI[i]) begin
        rd_hit  = 1'b1;
        rd_word = {24'h00_0000, mag_out_ff[i][15:8]};
      end
      if (addr_ok && idx == IDX_MAG_LO[i]) begin
        rd_hit  = 1'b1;
        rd_word = {24'h00_0000, mag_out_ff[i][7:0]};
      end
    end
  end

  // response capture in setup; unmapped addresses answer with an error
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prdata_ff <= 32'h0000_0000;
      slverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= i_pwrite ? 32'h0000_0000 : rd_word;
      slverr_ff <= ~rd_hit;
    end
  end

  // standby / active control
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      active_ff <= RST_CTRL;
    end else if (wr_ok && idx == IDX_CTRL && i_pstrb[0]) begin
      active_ff <= i_pwdata[CTRL_ACTIVE_BIT];
    end
  end

  // offset registers, writable only in standby
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      acc_off_ff <= {AXES{RST_OFF}};
    end else begin
      for (int i = 0; i < AXES; i++) begin
        if (wr_ok && idx == IDX_OFF[i] && i_pstrb[0] && !active_ff) begin
          acc_off_ff[i] <= i_pwdata[7:0];
        end
      end
    end
  end

  // refused offset write is reported, not stored
  always_comb begin
    off_refused = 1'b0;
    for (int i = 0; i < AXES; i++) begin
      if (wr_ok && idx == IDX_OFF[i] && active_ff) begin
        off_refused = 1'b1;
      end
    end
  end

  // corrected acceleration output registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      acc_out_ff <= '0;
    end else if (i_acc.valid && active_ff) begin
      for (int i = 0; i < AXES; i++) begin
        acc_out_ff[i] <= sat_add(i_acc.axis[i], acc_off_ff[i]);
      end
    end
  end

  // magnetic output registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mag_out_ff <= '0;
    end else begin
      for (int i = 0; i < AXES; i++) begin
        if (mag_new[i]) begin
          mag_out_ff[i] <= i_mag.axis[i];
        end
      end
    end
  end

  // per-axis events; clear takes effect at the read's completing edge
  always_comb begin
    for (int i = 0; i < AXES; i++) begin
      mag_new[i] = i_mag.done[i] & active_ff;
      hi_read[i] = rd_ok && idx == IDX_MAG_HI[i];
      ow_evt[i]  = mag_new[i] & mag_dr_ff[i] & ~hi_read[i];
      nxt_dr[i]  = mag_new[i] | (mag_dr_ff[i] & ~hi_read[i]);
    end
    set_new  = (|mag_new) & (&nxt_dr);
    all_read = &(seen_ff | hi_read);
  end

  // per-axis ready and overwrite flags; a new sample wins over a high byte read for ready, the read wins for overwrite
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mag_dr_ff <= 3'h0;
      mag_ow_ff <= 3'h0;
    end else begin
      mag_dr_ff <= nxt_dr;
      mag_ow_ff <= ow_evt | (mag_ow_ff & ~hi_read);
    end
  end

  // set-level flags and tracking of high bytes read since the last set
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      set_dr_ff <= 1'b0;
      set_ow_ff <= 1'b0;
      seen_ff   <= 3'h0;
    end else begin
      set_dr_ff <= set_new | (set_dr_ff & ~all_read);
      set_ow_ff <= (|ow_evt) | (set_ow_ff & ~all_read);
      if (set_new || all_read) begin
        seen_ff <= 3'h0;
      end else begin
        seen_ff <= seen_ff | hi_read;
      end
    end
  end

  // interrupt sources
  always_comb begin
    irq_evt                  = '0;
    irq_evt[IRQ_ACC_DONE]    = i_acc.valid & active_ff;
    irq_evt[IRQ_MAG_SET]     = set_new;
    irq_evt[IRQ_MAG_OW]      = |ow_evt;
    irq_evt[IRQ_OFF_REFUSED] = off_refused;
  end

  // sticky status with write-one-to-clear, new events win
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_sts_ff <= '0;
    end else if (wr_ok && idx == IDX_IRQ_STS && i_pstrb[0]) begin
      irq_sts_ff <= (irq_sts_ff & ~i_pwdata[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_sts_ff <= irq_sts_ff | irq_evt;
    end
  end

  // interrupt mask
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_msk_ff <= RST_MSK;
    end else if (wr_ok && idx == IDX_IRQ_MSK && i_pstrb[0]) begin
      irq_msk_ff <= i_pwdata[IRQ_W-1:0];
    end
  end

  assign o_irq = |(irq_sts_ff & irq_msk_ff);

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_acc_sum;
    (i_acc.valid && active_ff && $signed(i_acc.axis[0]) < $signed(16'h7D00)
      && $signed(i_acc.axis[0]) > $signed(16'h8300))
    |=> ($signed(acc_out_ff[0]) ==
         $signed($past(i_acc.axis[0])) + 2 * $signed($past(acc_off_ff[0])));
  endproperty
  a_acc_sum: assert property (p_acc_sum)
    else $error("corrected x sample wrong");

  property p_acc_hold;
    (!i_acc.valid || !active_ff) |=> $stable(acc_out_ff);
  endproperty
  a_acc_hold: assert property (p_acc_hold)
    else $error("acceleration output changed without a sample");

  property p_off_standby;
    (wr_ok && active_ff) |=> $stable(acc_off_ff);
  endproperty
  a_off_standby: assert property (p_off_standby)
    else $error("offset written while active");

  property p_off_write;
    (wr_ok && idx == IDX_OFF[0] && i_pstrb[0] && !active_ff)
    |=> (acc_off_ff[0] == $past(i_pwdata[7:0]));
  endproperty
  a_off_write: assert property (p_off_write)
    else $error("x offset not stored in standby");

  property p_sts_read;
    (setup && !i_pwrite && addr_ok && idx == IDX_MAG_STS)
    |=> (o_prdata == {24'h00_0000, $past(set_ow_ff), $past(mag_ow_ff),
                      $past(set_dr_ff), $past(mag_dr_ff)});
  endproperty
  a_sts_read: assert property (p_sts_read)
    else $error("status layout wrong");

  property p_dr_set;
    (i_mag.done[2] && active_ff) |=> mag_dr_ff[2] ##0 (mag_out_ff[2] == $past(i_mag.axis[2]));
  endproperty
  a_dr_set: assert property (p_dr_set)
    else $error("z ready or data not updated");

  property p_dr_clr;
    (rd_ok && idx == IDX_MAG_HI[0] && !(i_mag.done[0] && active_ff)) |=> !mag_dr_ff[0];
  endproperty
  a_dr_clr: assert property (p_dr_clr)
    else $error("x ready not cleared by high byte read");

  property p_ow_set;
    (i_mag.done[0] && active_ff && mag_dr_ff[0] && !hi_read[0]) |=> mag_ow_ff[0] && set_ow_ff;
  endproperty
  a_ow_set: assert property (p_ow_set)
    else $error("x overwrite not flagged");

  property p_set_clr;
    (all_read && !set_new && (mag_ow_ff == 3'h0) && !(|ow_evt)) |=> !set_dr_ff && !set_ow_ff;
  endproperty
  a_set_clr: assert property (p_set_clr)
    else $error("set flags not cleared after all high bytes read");

  property p_set_new;
    set_new |=> set_dr_ff ##1 (set_dr_ff || $past(all_read));
  endproperty
  a_set_new: assert property (p_set_new)
    else $error("set ready not raised");

  property p_mag_low;
    (setup && !i_pwrite && addr_ok && idx == IDX_MAG_LO[0])
    |=> (o_prdata == {24'h00_0000, $past(mag_out_ff[0][7:0])});
  endproperty
  a_mag_low: assert property (p_mag_low)
    else $error("x low byte wrong");

  property p_clear_after;
    (setup && !i_pwrite && addr_ok && idx == IDX_MAG_HI[0] && mag_dr_ff[0])
    |=> mag_dr_ff[0] ##1 (!mag_dr_ff[0] || $past(mag_new[0]));
  endproperty
  a_clear_after: assert property (p_clear_after)
    else $error("ready cleared before read completed");

  c_overwrite: cover property (mag_new[0] && mag_dr_ff[0]);
  c_set_read:  cover property (set_dr_ff ##[1:50] all_read);
  c_refused:   cover property (off_refused);
  c_irq:       cover property (o_irq);

endmodule // aomst_top

`default_nettype wire
